/* rtl/tpm_mux.sv */
// Channel 1 transmit input pin multiplexer for data pins 6 and 7.
// Assumes all pin inputs are asynchronous to i_clock and a downstream
// consumer of captured bytes and bits on i_clock.
// Function
// - Telecom bus enable outranks configured mode.
// - Capture add bus on its clock fall.
// - Bit 6 pin is HDLC bit 6.
// - Drive HDLC byte clock, sample on rise.
// - Sample serial payload on input clock rise.
// - Bit 7 high requests AIS, low suppresses.
`timescale 1ns/1ps
`include "tpm_consts.svh"
module tpm_mux #(
   parameter int HDLC_DIV = `TPM_HDLC_DIV,
   parameter int FIFO_DEPTH = `TPM_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_resetn,
   // Configuration.
   input wire logic i_add_bus_enable,
   input wire tpm_pkg::tpm_mode_e i_mode,
   // Pins.
   input wire logic [`TPM_BYTE_W-1:0] i_add_bus_ch1,
   input wire logic i_add_bus_clock_ch1,
   input wire logic i_tx_payload_input_clock,
   output logic o_hdlc_tx_byte_clock_ch1,
   // Captured bytes toward the channel logic.
   output logic o_byte_valid,
   output logic [`TPM_BYTE_W-1:0] o_byte_data,
   output logic o_byte_from_hdlc,
   input wire logic i_byte_ready,
   output logic o_byte_overflow,
   // Serial payload and AIS toward the framer.
   output logic o_payload_valid,
   output logic o_payload_bit,
   output logic o_ais_request_ch1
);
   localparam int DW = $clog2(HDLC_DIV);
   logic [`TPM_BYTE_W-1:0] bus_s1_r;
   logic [`TPM_BYTE_W-1:0] bus_s2_r;
   logic [2:0] aclk_r;
   logic [2:0] pclk_r;
   logic [DW-1:0] div_r;
   logic hclk_r;
   tpm_pkg::tpm_role_e role;
   logic add_fall;
   logic pay_rise;
   logic hdlc_rise;
   logic cap_valid;
   logic [`TPM_BYTE_W:0] cap_data;
   logic fifo_ready;
   logic [`TPM_BYTE_W:0] fifo_out;

   // Role decode shared by capture, serial and AIS paths.
   function automatic tpm_pkg::tpm_role_e role_of(input logic en,
                                                  input tpm_pkg::tpm_mode_e m);
      if (en) begin
         return tpm_pkg::TPM_ROLE_ADD;
      end
      case (m)
         tpm_pkg::TPM_MODE_HDLC: return tpm_pkg::TPM_ROLE_HDLC;
         tpm_pkg::TPM_MODE_CLEAR: return tpm_pkg::TPM_ROLE_CLEAR;
         default: return tpm_pkg::TPM_ROLE_FRAMER;
      endcase
   endfunction : role_of

   assign role = role_of(i_add_bus_enable, i_mode);

   // Two-stage synchronisers; stage two feeds logic, and a third clock stage feeds the edge detectors.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         bus_s1_r <= '0;
         bus_s2_r <= '0;
         aclk_r <= '0;
         pclk_r <= '0;
      end else begin
         bus_s1_r <= i_add_bus_ch1;
         bus_s2_r <= bus_s1_r;
         aclk_r <= {aclk_r[1:0], i_add_bus_clock_ch1};
         pclk_r <= {pclk_r[1:0], i_tx_payload_input_clock};
      end
   end

   // Pin clocks are slow against i_clock, so data settled well before the
   // sampled edge and the two synchronised copies stay aligned.
   assign add_fall = aclk_r[2] && !aclk_r[1];
   assign pay_rise = !pclk_r[2] && pclk_r[1];

   // HDLC byte clock is derived from i_clock by a divider.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         div_r <= '0;
         hclk_r <= 1'b0;
      end else if (role != tpm_pkg::TPM_ROLE_HDLC) begin
         div_r <= '0;
         hclk_r <= 1'b0;
      end else begin
         div_r <= (div_r == DW'(HDLC_DIV / 2 - 1)) ? '0 : div_r + 1'b1;
         if (div_r == DW'(HDLC_DIV / 2 - 1)) begin
            hclk_r <= !hclk_r;
         end
      end
   end
   assign hdlc_rise = (role == tpm_pkg::TPM_ROLE_HDLC) && !hclk_r &&
                      (div_r == DW'(HDLC_DIV / 2 - 1));
   assign o_hdlc_tx_byte_clock_ch1 = hclk_r;

   // Bit 7 lands on bit 7 and bit 6 on bit 6 in both bus roles.
   assign cap_valid = ((role == tpm_pkg::TPM_ROLE_ADD) && add_fall) ||
                      hdlc_rise;
   assign cap_data = {(role == tpm_pkg::TPM_ROLE_HDLC), bus_s2_r};

   tpm_fifo #(
      .WIDTH(`TPM_BYTE_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_in_valid(cap_valid),
      .i_in_data(cap_data),
      .o_in_ready(fifo_ready),
      .o_out_valid(o_byte_valid),
      .o_out_data(fifo_out),
      .i_out_ready(i_byte_ready)
   );
   assign o_byte_data = fifo_out[`TPM_BYTE_W-1:0];
   assign o_byte_from_hdlc = fifo_out[`TPM_BYTE_W];

   // Pin sources cannot be stalled, so a byte offered to a full FIFO is
   // lost and flagged until reset.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_byte_overflow <= 1'b0;
      end else if (cap_valid && !fifo_ready) begin
         o_byte_overflow <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_payload_valid <= 1'b0;
         o_payload_bit <= 1'b0;
      end else begin
         o_payload_valid <= (role == tpm_pkg::TPM_ROLE_CLEAR) && pay_rise;
         if ((role == tpm_pkg::TPM_ROLE_CLEAR) && pay_rise) begin
            o_payload_bit <= bus_s2_r[`TPM_BIT6];
         end
      end
   end

   // A pin tied low under software control keeps AIS off here.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ais_request_ch1 <= 1'b0;
      end else begin
         o_ais_request_ch1 <= (role == tpm_pkg::TPM_ROLE_FRAMER) &&
                              bus_s2_r[`TPM_BIT7];
      end
   end

   role_priority_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      i_add_bus_enable |-> ##1 !o_payload_valid && !o_ais_request_ch1)
      else $error("Alternate role active with bus enabled.");
   add_capture_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      role == tpm_pkg::TPM_ROLE_ADD && add_fall && fifo_ready |=>
      o_byte_valid)
      else $error("Add bus byte not captured on falling edge.");
   // Checked at the FIFO head while it was empty, so the whole path counts.
   bit_order_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      role == tpm_pkg::TPM_ROLE_ADD && add_fall && !o_byte_valid |=>
      o_byte_data[`TPM_BIT7] == $past(bus_s2_r[`TPM_BIT7]))
      else $error("Bit 7 pin not on byte MSB.");
   hdlc_bit6_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      hdlc_rise && !o_byte_valid |=> o_byte_from_hdlc &&
      o_byte_data[`TPM_BIT6] == $past(bus_s2_r[`TPM_BIT6]))
      else $error("HDLC bit 6 misplaced.");
   hdlc_clock_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      hdlc_rise |=> o_hdlc_tx_byte_clock_ch1 && cap_data[`TPM_BYTE_W] == 1'b1)
      else $error("HDLC sample not on byte clock rise.");
   hdlc_msb_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      hdlc_rise && !o_byte_valid |=>
      o_byte_data[`TPM_BIT7] == $past(bus_s2_r[`TPM_BIT7]))
      else $error("HDLC bit 7 misplaced.");
   payload_sample_a: assert property (@(posedge i_clock)
      disable iff (!i_resetn)
      role == tpm_pkg::TPM_ROLE_CLEAR && pay_rise |=>
      o_payload_valid && o_payload_bit == $past(bus_s2_r[`TPM_BIT6]))
      else $error("Serial payload not sampled on clock rise.");
   ais_follow_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      role == tpm_pkg::TPM_ROLE_FRAMER && $stable(role) |=>
      o_ais_request_ch1 == $past(bus_s2_r[`TPM_BIT7]))
      else $error("AIS request does not follow pin.");
endmodule : tpm_mux

/* common/tpm_consts.svh */
// Constants for the channel 1 transmit input pin multiplexer.
// Assumes inclusion by bare name from the design files.
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH
`define TPM_CLK_PERIOD_NS 50
`define TPM_HDLC_DIV 8
`define TPM_BYTE_W 8
`define TPM_FIFO_DEPTH 8
`define TPM_BIT6 6
`define TPM_BIT7 7
`endif

/* common/tpm_pkg.sv */
// Types for the channel 1 transmit input pin multiplexer.
// Assumes nothing of its surroundings.
package tpm_pkg;
   typedef enum logic [1:0] {
      TPM_MODE_HDLC,
      TPM_MODE_CLEAR,
      TPM_MODE_FRAMER
   } tpm_mode_e;
   typedef enum logic [1:0] {
      TPM_ROLE_ADD,
      TPM_ROLE_HDLC,
      TPM_ROLE_CLEAR,
      TPM_ROLE_FRAMER
   } tpm_role_e;
endpackage : tpm_pkg

/* rtl/tpm_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module tpm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_resetn,
   // Fill side.
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side.
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign o_in_ready = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != '0);
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem_r[rd_ptr_r];

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   fifo_bound_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      count_r <= DEPTH[AW:0])
      else $error("FIFO count above depth.");
endmodule : tpm_fifo

/* test/tpm_term_model.sv */
// Terminal equipment model driving the channel 1 transmit input pins.
// Assumes the caller starts each task just after a rising i_clock edge.
`timescale 1ns/1ps
module tpm_term_model (
   // Pins toward the multiplexer.
   output logic [7:0] o_add_bus,
   output logic o_add_clk,
   output logic o_pay_clk
);
   initial begin
      o_add_bus = 8'h00;
      o_add_clk = 1'b0;
      o_pay_clk = 1'b0;
   end
   task automatic set_bus(input logic [7:0] b);
      o_add_bus = b;
   endtask : set_bus
   // The clock stands low between bytes; data is inverted once its hold ends.
   task automatic send_add(input logic [7:0] b);
      o_add_bus = b;
      o_add_clk = 1'b1;
      #200;
      o_add_clk = 1'b0;
      #200;
      o_add_bus = ~b;
   endtask : send_add
   task automatic send_bit(input logic b);
      o_add_bus[6] = b;
      o_pay_clk = 1'b1;
      #200;
      o_pay_clk = 1'b0;
      #200;
      o_add_bus[6] = ~b;
   endtask : send_bit
endmodule : tpm_term_model

/* test/tb.sv */
// Self-checking bench for the channel 1 transmit input multiplexer.
// Assumes the terminal model drives all pins; configuration changes only as reset is applied.
`timescale 1ns/1ps
`include "tpm_consts.svh"
module tb;
   logic i_clock, i_resetn, en, pop, aclk, pclk, hclk;
   logic bv, bh, ovf, pv, pb, ais;
   logic [7:0] pins, bd;
   tpm_pkg::tpm_mode_e mode;
   int num_errors = 0;
   int compares = 0;
   tpm_term_model model_u (.o_add_bus(pins), .o_add_clk(aclk),
      .o_pay_clk(pclk));
   tpm_mux dut_u (.i_clock(i_clock),
      .i_resetn(i_resetn), .i_add_bus_enable(en), .i_mode(mode),
      .i_add_bus_ch1(pins), .i_add_bus_clock_ch1(aclk),
      .i_tx_payload_input_clock(pclk), .o_hdlc_tx_byte_clock_ch1(hclk),
      .o_byte_valid(bv), .o_byte_data(bd), .o_byte_from_hdlc(bh),
      .i_byte_ready(pop), .o_byte_overflow(ovf), .o_payload_valid(pv),
      .o_payload_bit(pb), .o_ais_request_ch1(ais));
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : tick
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic reset_to(input logic e, input tpm_pkg::tpm_mode_e m);
      en = e;
      mode = m;
      i_resetn = 1'b0;
      tick(6);
      chk(bv === 1'b0 && ovf === 1'b0 && ais === 1'b0, "reset outputs");
      i_resetn = 1'b1;
   endtask : reset_to
   task automatic wait_byte;
      int n;
      n = 0;
      while (bv !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      if (bv !== 1'b1) begin
         chk(1'b0, "byte timeout");
         end_sim();
      end
   endtask : wait_byte
   // Fill past depth with the consumer stalled, then drain in order.
   task automatic t_add_fifo;
      reset_to(1'b1, tpm_pkg::TPM_MODE_HDLC);
      for (int i = 0; i < 9; i++) begin
         model_u.send_add(8'h3C + 8'h45 * i[7:0]);
         if (i == 7) chk(ovf === 1'b0, "early overflow");
      end
      tick(2);
      chk(ovf === 1'b1 && hclk === 1'b0, "overflow flag");
      for (int i = 0; i < 8; i++) begin
         wait_byte();
         chk(bd === 8'h3C + 8'h45 * i[7:0] && bh === 1'b0, "add byte");
         pop = 1'b1;
         tick(1);
         pop = 1'b0;
      end
      chk(bv === 1'b0, "fifo not empty");
      $display("add bus and fifo done");
   endtask : t_add_fifo
   // Bits 7 and 6 set, bit 5 clear, so a swapped pin shows.
   task automatic t_hdlc;
      int n;
      model_u.set_bus(8'hC0);
      reset_to(1'b0, tpm_pkg::TPM_MODE_HDLC);
      wait_byte();
      chk(bd === 8'hC0 && bh === 1'b1 && hclk === 1'b1, "hdlc byte");
      n = 0;
      while (hclk === 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk(n == `TPM_HDLC_DIV / 2, "hdlc clock high phase");
      $display("hdlc done");
   endtask : t_hdlc
   task automatic t_serial;
      int seen;
      reset_to(1'b0, tpm_pkg::TPM_MODE_CLEAR);
      for (int k = 0; k < 3; k++) begin
         seen = 0;
         fork
            model_u.send_bit(k[0] ^ 1'b1);
            repeat (10) begin
               tick(1);
               if (pv === 1'b1) begin
                  seen++;
                  chk(pb === (k[0] ^ 1'b1), "serial bit");
               end
            end
         join
         chk(seen == 1, "one pulse per bit");
      end
      chk(bv === 1'b0 && hclk === 1'b0 && ais === 1'b0, "clear role");
      $display("serial done");
   endtask : t_serial
   task automatic t_ais;
      reset_to(1'b0, tpm_pkg::TPM_MODE_FRAMER);
      model_u.set_bus(8'h80);
      tick(4);
      chk(ais === 1'b1, "ais high");
      model_u.set_bus(8'h00);
      tick(4);
      chk(ais === 1'b0, "ais low");
      reset_to(1'b1, tpm_pkg::TPM_MODE_FRAMER);
      model_u.set_bus(8'h80);
      tick(4);
      chk(ais === 1'b0, "ais in add role");
      $display("ais done");
   endtask : t_ais
   initial begin
      i_resetn = 1'b0;
      en = 1'b0;
      pop = 1'b0;
      mode = tpm_pkg::TPM_MODE_HDLC;
      tick(1);
      t_add_fifo();
      t_hdlc();
      t_serial();
      t_ais();
      end_sim();
   end
endmodule : tb
